// file: core/csfr_pkg.sv
/*
 Constants shared by the core special function register block: file addresses,
 status bit positions, reset values and the program counter source selector.
 Assumes nothing of its surroundings.
*/
package csfr_pkg;

  // ---------------------------------------------------------------------------
  // File addresses
  // ---------------------------------------------------------------------------
  localparam logic [4:0] ADDR_INDIRECT  = 5'h00;
  localparam logic [4:0] ADDR_TIMER     = 5'h01;
  localparam logic [4:0] ADDR_PCL       = 5'h02;
  localparam logic [4:0] ADDR_STATUS    = 5'h03;
  localparam logic [4:0] ADDR_POINTER   = 5'h04;
  localparam logic [4:0] ADDR_PORT_A    = 5'h05;
  localparam logic [4:0] ADDR_PORT_B    = 5'h06;
  localparam logic [4:0] ADDR_PORT_C    = 5'h07;

  // ---------------------------------------------------------------------------
  // Status register layout
  // ---------------------------------------------------------------------------
  localparam int STAT_PA_LSB = 5;
  localparam int STAT_TO     = 4;
  localparam int STAT_PD     = 3;
  localparam int STAT_FLAGS  = 3;

  // ---------------------------------------------------------------------------
  // Reset values and page offset width
  // ---------------------------------------------------------------------------
  localparam logic [7:0] STATUS_POR      = 8'h18;
  localparam logic [7:0] DIR_RESET       = 8'hff;
  localparam logic [5:0] OPTION_RESET    = 6'h3f;
  localparam logic [7:0] PTR_SET_SMALL   = 8'he0;
  localparam logic [7:0] PTR_KEEP_SMALL  = 8'h1f;
  localparam logic [7:0] PTR_SET_LARGE   = 8'h80;
  localparam logic [7:0] PTR_KEEP_LARGE  = 8'h7f;
  localparam int         PAGE_OFFSET_W   = 9;

  // ---------------------------------------------------------------------------
  // Program counter source
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PC_HOLD,
    PC_STEP,
    PC_JUMP,
    PC_CALL,
    PC_RET,
    PC_PCL
  } csfr_pc_src_type;

endpackage : csfr_pkg

// file: core/csfr_stack.sv
/*
 Two-level return address stack.
 Assumes push and pop are never asserted together.
*/
`timescale 1ns/1ns
module csfr_stack
  import csfr_pkg::*;
#(
  parameter int W = 11
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  output logic      [W-1:0] stack_top,
  output logic      [W-1:0] stack_second
);

  // Level two is never cleared by a pop, so deep returns keep reusing it.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stack_top    <= '0;
      stack_second <= '0;
    end else if (push) begin
      stack_second <= stack_top;
      stack_top    <= push_data;
    end else if (pop) begin
      stack_top    <= stack_second;
    end
  end

  chk_push_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    push |=> stack_top == $past(push_data) && stack_second == $past(stack_top))
    else $error("push did not shift level one into level two");

  chk_pop_reuse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pop ##1 pop |=> stack_top == $past(stack_second, 2) && $stable(stack_second))
    else $error("repeated pop did not reuse level two");

endmodule : csfr_stack

// file: core/csfr_port.sv
/*
 One group of bidirectional pins: output latch, direction register and a
 two-stage synchroniser for the sensed pin levels.
 Assumes pin_in is asynchronous to ref_clk.
*/
`timescale 1ns/1ns
module csfr_port
  import csfr_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  input  wire logic         latch_we,
  input  wire logic [W-1:0] latch_wdata,
  input  wire logic         dir_we,
  input  wire logic [W-1:0] dir_wdata,
  output logic      [W-1:0] pin_level,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_n
);

  logic [W-1:0] sync_1;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_1    <= '0;
      pin_level <= '0;
    end else begin
      sync_1    <= pin_in;
      pin_level <= sync_1;
    end
  end

  // The latch takes its value on the edge that closes the write cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_out <= '0;
    end else if (latch_we) begin
      pin_out <= latch_wdata;
    end
  end

  // A set direction bit makes the pin an input, so it also releases the driver.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_oe_n <= DIR_RESET[W-1:0];
    end else if (dir_we) begin
      pin_oe_n <= dir_wdata;
    end
  end

  chk_latch_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    latch_we |=> pin_out == $past(latch_wdata))
    else $error("port latch did not take the written byte");

endmodule : csfr_port

// file: core/csfr_core.sv
/*
 Core special function register file: program counter with paging, status,
 indirect pointer, general purpose registers, return stack and pin groups.
 Assumes an instruction sequencer on ref_clk issuing at most one of
 file_wr, bit_op, jump_op, call_op and ret_op per instruction cycle.
*/
// Operation
// - Sequential increment crosses into the next page; page bits stay unchanged.
// - Jump, call and low counter write take upper bits from page bits.
// - Any reset loads the program counter with all ones.
// - Any reset clears all page preselect bits.
// - Return stack has exactly two levels, each as wide as the counter.
// - Call copies level one to level two, then pushes counter plus one.
// - Return loads counter from level one, then copies level two down.
// - Return also loads the literal into the accumulator simultaneously.
// - Return restores the full address regardless of page bits.
// - Only the low eight counter bits are mapped, at address 02h.
// - Address 00h reaches the location named by the pointer at 04h.
// - Without the third port, address 07h is a general register.
// - Small variants set pointer top three bits on reset; warm reset keeps low five.
// - Unimplemented register bits, like port A upper nibble, read zero.
// - Bit set and clear read all pins, modify one bit, rewrite latches.
// - Port writes land at cycle end; port reads sample at cycle start.
`timescale 1ns/1ns
module csfr_core
  import csfr_pkg::*;
#(
  parameter int PC_W         = 11,
  parameter bit HAS_PORT_C   = 1'b1,
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            rst_is_por,
  input  wire logic [4:0]      file_addr,
  input  wire logic            file_rd,
  input  wire logic            file_wr,
  input  wire logic [7:0]      file_wdata,
  output logic      [7:0]      rd_data,
  input  wire logic            bit_op,
  input  wire logic            bit_set,
  input  wire logic [2:0]      bit_sel,
  input  wire logic [2:0]      flag_we,
  input  wire logic [2:0]      flag_in,
  input  wire logic            pwr_flag_we,
  input  wire logic            timeout_in,
  input  wire logic            powerdown_in,
  input  wire logic            pc_step,
  input  wire logic            jump_op,
  input  wire logic [8:0]      jump_k,
  input  wire logic            call_op,
  input  wire logic [7:0]      call_k,
  input  wire logic            ret_op,
  input  wire logic [7:0]      ret_literal,
  output logic      [PC_W-1:0] pc,
  output logic                 acc_load,
  output logic      [7:0]      acc_literal,
  input  wire logic            dir_wr,
  input  wire logic [4:0]      dir_addr,
  input  wire logic [7:0]      dir_wdata,
  input  wire logic            opt_wr,
  input  wire logic [5:0]      opt_wdata,
  output logic      [5:0]      option_cfg,
  input  wire logic [7:0]      timer_count_in,
  output logic                 timer_wr,
  output logic      [7:0]      timer_wdata,
  input  wire logic [3:0]      pin_a_in,
  output logic      [3:0]      pin_a_out,
  output logic      [3:0]      pin_a_oe_n,
  input  wire logic [7:0]      pin_b_in,
  output logic      [7:0]      pin_b_out,
  output logic      [7:0]      pin_b_oe_n,
  input  wire logic [7:0]      pin_c_in,
  output logic      [7:0]      pin_c_out,
  output logic      [7:0]      pin_c_oe_n
);

  localparam int PAGE_W = PC_W - PAGE_OFFSET_W;

  // ---------------------------------------------------------------------------
  // Address resolution
  // ---------------------------------------------------------------------------
  function automatic logic [4:0] csfr_eff_addr(input logic [4:0] a, input logic [7:0] p);
    return (a == ADDR_INDIRECT) ? p[4:0] : a;
  endfunction : csfr_eff_addr

  logic [7:0]        status;
  logic [7:0]        next_status;
  logic [7:0]        pointer;
  logic [7:0]        gpr [0:31];
  logic [4:0]        eff;
  logic [7:0]        rd_value;
  logic [7:0]        bit_mask;
  logic              wr_en;
  logic [7:0]        wr_data;
  logic [PC_W-1:0]   pc_plus1;
  logic [PC_W-1:0]   stack_top;
  logic [PAGE_W-1:0] page_sel;
  logic [3:0]        a_level;
  logic [7:0]        b_level;
  logic [7:0]        c_level;
  logic              is_gpr;
  csfr_pc_src_type   pc_src;

  assign eff      = csfr_eff_addr(file_addr, pointer);
  assign bit_mask = 8'h01 << bit_sel;
  assign pc_plus1 = pc + 1'b1;
  assign page_sel = status[STAT_PA_LSB +: PAGE_W];
  assign is_gpr   = (eff > ADDR_PORT_C) || (eff == ADDR_PORT_C && !HAS_PORT_C);

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_value = 8'h00;
    case (eff)
      ADDR_INDIRECT: rd_value = 8'h00;
      ADDR_TIMER:    rd_value = timer_count_in;
      ADDR_PCL:      rd_value = pc[7:0];
      ADDR_STATUS:   rd_value = status;
      ADDR_POINTER:  rd_value = pointer;
      ADDR_PORT_A:   rd_value = {4'h0, a_level};
      ADDR_PORT_B:   rd_value = b_level;
      default:       rd_value = (eff == ADDR_PORT_C && HAS_PORT_C) ? c_level : gpr[eff];
    endcase
  end

  // The pins are sampled at the edge that opens the read cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (file_rd) begin
      rd_data <= rd_value;
    end
  end

  // ---------------------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------------------
  // A bit operation is a read-modify-write of the whole byte; on a port the
  // byte read is the sensed pin level, so input pins overwrite their latches.
  assign wr_en   = file_wr || bit_op;
  assign wr_data = file_wr ? file_wdata :
                   (bit_set ? (rd_value | bit_mask) : (rd_value & ~bit_mask));

  always_ff @(posedge ref_clk) begin
    if (wr_en && is_gpr) begin
      gpr[eff] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer_wr    <= 1'b0;
      timer_wdata <= 8'h00;
    end else begin
      timer_wr    <= wr_en && eff == ADDR_TIMER;
      timer_wdata <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      option_cfg <= OPTION_RESET;
    end else if (opt_wr) begin
      option_cfg <= opt_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Indirect pointer
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      if (SMALL_VARIANT) begin
        pointer <= rst_is_por ? PTR_SET_SMALL : (PTR_SET_SMALL | (pointer & PTR_KEEP_SMALL));
      end else begin
        pointer <= rst_is_por ? PTR_SET_LARGE : (PTR_SET_LARGE | (pointer & PTR_KEEP_LARGE));
      end
    end else if (wr_en && eff == ADDR_POINTER) begin
      pointer <= wr_data;
    end
  end

  // ---------------------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------------------
  // Timeout and powerdown are written only by the power control side.
  always_comb begin
    next_status = status;
    if (wr_en && eff == ADDR_STATUS) begin
      next_status = {wr_data[7:STAT_PA_LSB], status[STAT_TO:STAT_PD], wr_data[2:0]};
    end
    if (pwr_flag_we) begin
      next_status[STAT_TO] = timeout_in;
      next_status[STAT_PD] = powerdown_in;
    end
    for (int i = 0; i < STAT_FLAGS; i++) begin
      if (flag_we[i]) begin
        next_status[i] = flag_in[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= rst_is_por ? STATUS_POR : {3'b000, status[4:0]};
    end else begin
      status <= next_status;
    end
  end

  // ---------------------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------------------
  always_comb begin
    if (ret_op) begin
      pc_src = PC_RET;
    end else if (call_op) begin
      pc_src = PC_CALL;
    end else if (jump_op) begin
      pc_src = PC_JUMP;
    end else if (wr_en && eff == ADDR_PCL) begin
      pc_src = PC_PCL;
    end else if (pc_step) begin
      pc_src = PC_STEP;
    end else begin
      pc_src = PC_HOLD;
    end
  end

  // Bit 8 is cleared on a call or low byte write, so subroutines start in the
  // lower half of a page.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pc <= '1;
    end else begin
      unique case (pc_src)
        PC_HOLD: pc <= pc;
        PC_STEP: pc <= pc_plus1;
        PC_JUMP: pc <= {page_sel, jump_k};
        PC_CALL: pc <= {page_sel, 1'b0, call_k};
        PC_PCL:  pc <= {page_sel, 1'b0, wr_data};
        PC_RET:  pc <= stack_top;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_load    <= 1'b0;
      acc_literal <= 8'h00;
    end else begin
      acc_load    <= pc_src == PC_RET;
      acc_literal <= ret_op ? ret_literal : acc_literal;
    end
  end

  csfr_stack #(
    .W (PC_W)
  ) u_stack (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .push         (pc_src == PC_CALL),
    .push_data    (pc_plus1),
    .pop          (pc_src == PC_RET),
    .stack_top    (stack_top),
    .stack_second ()
  );

  // ---------------------------------------------------------------------------
  // Pin groups
  // ---------------------------------------------------------------------------
  csfr_port #(
    .W (4)
  ) u_port_a (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .pin_in      (pin_a_in),
    .latch_we    (wr_en && eff == ADDR_PORT_A),
    .latch_wdata (wr_data[3:0]),
    .dir_we      (dir_wr && dir_addr == ADDR_PORT_A),
    .dir_wdata   (dir_wdata[3:0]),
    .pin_level   (a_level),
    .pin_out     (pin_a_out),
    .pin_oe_n    (pin_a_oe_n)
  );

  csfr_port #(
    .W (8)
  ) u_port_b (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .pin_in      (pin_b_in),
    .latch_we    (wr_en && eff == ADDR_PORT_B),
    .latch_wdata (wr_data),
    .dir_we      (dir_wr && dir_addr == ADDR_PORT_B),
    .dir_wdata   (dir_wdata),
    .pin_level   (b_level),
    .pin_out     (pin_b_out),
    .pin_oe_n    (pin_b_oe_n)
  );

  generate
    if (HAS_PORT_C) begin : g_port_c
      csfr_port #(
        .W (8)
      ) u_port_c (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .pin_in      (pin_c_in),
        .latch_we    (wr_en && eff == ADDR_PORT_C),
        .latch_wdata (wr_data),
        .dir_we      (dir_wr && dir_addr == ADDR_PORT_C),
        .dir_wdata   (dir_wdata),
        .pin_level   (c_level),
        .pin_out     (pin_c_out),
        .pin_oe_n    (pin_c_oe_n)
      );
    end else begin : g_no_port_c
      assign c_level    = 8'h00;
      assign pin_c_out  = 8'h00;
      assign pin_c_oe_n = 8'hff;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_reset_vector: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> pc == {PC_W{1'b1}} && status[7:STAT_PA_LSB] == 3'b000)
    else $error("reset did not load the vector and clear page bits");

  chk_step_page: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pc_src == PC_STEP && !wr_en && flag_we == 3'b000
    |=> pc == $past(pc) + 1'b1 && $stable(status))
    else $error("sequential step wrong or page bits changed");

  chk_jump_page: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pc_src == PC_JUMP |=> pc == {$past(page_sel), $past(jump_k)})
    else $error("jump did not use the page preselect bits");

  chk_return_literal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pc_src == PC_RET |=> pc == $past(stack_top) && acc_load
    && acc_literal == $past(ret_literal))
    else $error("return did not restore address with the literal");

  chk_port_a_upper: assert property (@(posedge ref_clk) disable iff (!rst_n)
    file_rd && eff == ADDR_PORT_A |=> rd_data[7:4] == 4'h0)
    else $error("port A upper nibble did not read zero");

  chk_indirect_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    file_rd && file_addr == ADDR_INDIRECT && pointer[4:0] == ADDR_PCL
    |=> rd_data == $past(pc[7:0]))
    else $error("indirect read did not follow the pointer");

  chk_rmw_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bit_op && eff == ADDR_PORT_B
    |=> pin_b_out == ($past(bit_set) ? ($past(b_level) | $past(bit_mask))
                                     : ($past(b_level) & ~$past(bit_mask))))
    else $error("bit operation did not rewrite sensed pins");

  chk_pointer_reset: assert property (@(posedge ref_clk)
    !rst_n && !rst_is_por
    |=> pointer == (SMALL_VARIANT ? (PTR_SET_SMALL | ($past(pointer) & PTR_KEEP_SMALL))
                                  : (PTR_SET_LARGE | ($past(pointer) & PTR_KEEP_LARGE))))
    else $error("warm reset did not keep the pointer low bits");

endmodule : csfr_core

// file: verif/csfr_pin_model.sv
/*
 Far-side model of one pin group: a driven pin shows its latch, an undriven
 pin shows the external level. Assumes the bench sets that level.
*/
`timescale 1ns/1ns
module csfr_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe_n,
  input  wire logic [W-1:0] ext_level,
  output logic      [W-1:0] pin_in
);
  // Undriven pins take the external pull level, so a stale latch never leaks back.
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : csfr_pin_model

// file: verif/core_sfr_pc_stack_ports_tb.sv
/*
 Self-checking bench for csfr_core with default parameters.
 Assumes the package, the core and the pin model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module core_sfr_pc_stack_ports_tb;
  import csfr_pkg::*;
  logic        ref_clk = 0, rst_n = 0, rst_is_por = 1, file_rd = 0, file_wr = 0;
  logic        bit_op = 0, bit_set = 0, pwr_flag_we = 0, timeout_in = 0, powerdown_in = 0;
  logic        pc_step = 0, jump_op = 0, call_op = 0, ret_op = 0, dir_wr = 0, opt_wr = 0;
  logic [4:0]  file_addr = 0, dir_addr = 0;
  logic [2:0]  bit_sel = 0, flag_we = 0, flag_in = 0;
  logic [8:0]  jump_k = 0;
  logic [5:0]  opt_wdata = 0;
  logic [3:0]  ext_a = 4'ha;
  logic [7:0]  file_wdata = 0, call_k = 0, ret_literal = 0, dir_wdata = 0;
  logic [7:0]  timer_count_in = 8'h77, ext_b = 8'hcf, ext_c = 8'h3c, d, s;
  logic [7:0]  rd_data, acc_literal, timer_wdata, pin_b_in, pin_b_out, pin_b_oe_n;
  logic [7:0]  pin_c_in, pin_c_out, pin_c_oe_n;
  logic [3:0]  pin_a_in, pin_a_out, pin_a_oe_n;
  logic [10:0] pc;
  logic [5:0]  option_cfg;
  logic        acc_load, timer_wr;
  int          bad_count = 0, checked = 0;

  always #2 ref_clk = ~ref_clk;

  csfr_core u_csfr_core (.ref_clk, .rst_n, .rst_is_por, .file_addr, .file_rd, .file_wr,
    .file_wdata, .rd_data, .bit_op, .bit_set, .bit_sel, .flag_we, .flag_in, .pwr_flag_we,
    .timeout_in, .powerdown_in, .pc_step, .jump_op, .jump_k, .call_op, .call_k, .ret_op,
    .ret_literal, .pc, .acc_load, .acc_literal, .dir_wr, .dir_addr, .dir_wdata, .opt_wr,
    .opt_wdata, .option_cfg, .timer_count_in, .timer_wr, .timer_wdata, .pin_a_in,
    .pin_a_out, .pin_a_oe_n, .pin_b_in, .pin_b_out, .pin_b_oe_n, .pin_c_in, .pin_c_out,
    .pin_c_oe_n);
  csfr_pin_model #(.W(4)) u_csfr_pin_model_a (.pin_out(pin_a_out), .pin_oe_n(pin_a_oe_n),
    .ext_level(ext_a), .pin_in(pin_a_in));
  csfr_pin_model u_csfr_pin_model_b (.pin_out(pin_b_out), .pin_oe_n(pin_b_oe_n),
    .ext_level(ext_b), .pin_in(pin_b_in));
  csfr_pin_model u_csfr_pin_model_c (.pin_out(pin_c_out), .pin_oe_n(pin_c_oe_n),
    .ext_level(ext_c), .pin_in(pin_c_in));

  // ---------------------------------------------------------------------------
  // Bus and control helpers
  // ---------------------------------------------------------------------------
  // Each helper leaves at least one idle edge after its strobe so no strobe is reassigned
  // within the same time step by the next call.
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    file_addr = a;
    file_wdata = v;
    file_wr = 1;
    tick;
    file_wr = 0;
    tick;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    file_addr = a;
    file_rd = 1;
    tick;
    file_rd = 0;
    v = rd_data;
    tick;
  endtask : rd
  task automatic jmp(input logic [8:0] k, input logic [10:0] e);
    jump_k = k;
    jump_op = 1;
    tick;
    jump_op = 0;
    `CHK("pc_jump", e, pc)
    tick;
  endtask : jmp
  task automatic call(input logic [7:0] k, input logic [10:0] e);
    call_k = k;
    call_op = 1;
    tick;
    call_op = 0;
    `CHK("pc_call", e, pc)
    tick;
  endtask : call
  task automatic ret(input logic [7:0] k, input logic [10:0] e);
    ret_literal = k;
    ret_op = 1;
    tick;
    ret_op = 0;
    `CHK("pc_ret", e, pc)
    `CHK("acc_load", 1'b1, acc_load)
    `CHK("acc_literal", k, acc_literal)
    tick;
    `CHK("acc_load_end", 1'b0, acc_load)
  endtask : ret
  task automatic bop(input logic [2:0] b, input logic v, input logic [7:0] e);
    file_addr = ADDR_PORT_B;
    bit_sel = b;
    bit_set = v;
    bit_op = 1;
    tick;
    bit_op = 0;
    `CHK("latch_rmw", e, pin_b_out)
    repeat (3) tick;
  endtask : bop

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset(input int n, input logic por, input logic [7:0] es, input logic [7:0] ep);
    rst_is_por = por;
    rst_n = 0;
    repeat (n) tick;
    rst_n = 1;
    `CHK("pc_reset", 11'h7ff, pc)
    `CHK("option_reset", OPTION_RESET, option_cfg)
    `CHK("oe_reset", 20'hfffff, {pin_a_oe_n, pin_b_oe_n, pin_c_oe_n})
    `CHK("out_reset", 20'h00000, {pin_a_out, pin_b_out, pin_c_out})
    rd(ADDR_POINTER, d);
    `CHK("pointer_reset", ep, d)
    rd(ADDR_STATUS, d);
    `CHK("status_reset", es, d)
    rd(ADDR_PCL, d);
    `CHK("pcl_reset", 8'hff, d)
    $display("test reset done");
  endtask : t_reset
  task automatic t_page;
    wr(ADDR_STATUS, 8'h20);
    jmp(9'h1ff, 11'h3ff);
    pc_step = 1;
    tick;
    pc_step = 0;
    `CHK("pc_cross", 11'h400, pc)
    rd(ADDR_STATUS, d);
    `CHK("page_kept", 8'h20, d & 8'he0)
    jmp(9'h005, 11'h205);
    wr(ADDR_PCL, 8'h10);
    `CHK("pc_pcl", 11'h210, pc)
    rd(ADDR_PCL, d);
    `CHK("pcl_read", 8'h10, d)
    $display("test page done");
  endtask : t_page
  task automatic t_stack;
    wr(ADDR_STATUS, 8'h00);
    jmp(9'h005, 11'h005);
    call(8'h10, 11'h010);
    call(8'h20, 11'h020);
    call(8'h30, 11'h030);
    wr(ADDR_STATUS, 8'h60);
    ret(8'haa, 11'h021);
    ret(8'hbb, 11'h011);
    ret(8'hcc, 11'h011);
    $display("test stack done");
  endtask : t_stack
  task automatic t_ports;
    dir_addr = ADDR_PORT_B;
    dir_wdata = 8'hf0;
    dir_wr = 1;
    tick;
    dir_wr = 0;
    wr(ADDR_PORT_B, 8'h00);
    `CHK("latch_write", 8'h00, pin_b_out)
    `CHK("dir_b", 8'hf0, pin_b_oe_n)
    repeat (3) tick;
    bop(3'd0, 1'b1, 8'hc1);
    bop(3'd7, 1'b0, 8'h41);
    rd(ADDR_PORT_A, d);
    `CHK("port_a_read", 8'h0a, d)
    rd(ADDR_PORT_C, d);
    `CHK("port_c_read", 8'h3c, d)
    $display("test ports done");
  endtask : t_ports
  task automatic t_misc;
    wr(ADDR_POINTER, 8'h08);
    wr(ADDR_INDIRECT, 8'h3c);
    rd(5'h08, d);
    `CHK("indirect_wr", 8'h3c, d)
    rd(ADDR_INDIRECT, d);
    `CHK("indirect_rd", 8'h3c, d)
    wr(ADDR_POINTER, 8'h02);
    rd(ADDR_INDIRECT, d);
    `CHK("indirect_pcl", 8'h11, d)
    file_addr = ADDR_TIMER;
    file_wdata = 8'h5a;
    file_wr = 1;
    tick;
    file_wr = 0;
    `CHK("timer_wr", 1'b1, timer_wr)
    `CHK("timer_wdata", 8'h5a, timer_wdata)
    tick;
    rd(ADDR_TIMER, d);
    `CHK("timer_read", 8'h77, d)
    opt_wdata = 6'h15;
    opt_wr = 1;
    flag_we = 3'h7;
    flag_in = 3'h5;
    pwr_flag_we = 1;
    powerdown_in = 1;
    tick;
    {opt_wr, flag_we, pwr_flag_we} = 0;
    tick;
    `CHK("option", 6'h15, option_cfg)
    rd(ADDR_STATUS, s);
    `CHK("status_bits", 8'h6d, s)
    $display("test misc done");
  endtask : t_misc

  task automatic stop_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    bad_count++;
    stop_test;
  end

  initial begin
    #1;
    t_reset(16, 1'b1, STATUS_POR, PTR_SET_LARGE);
    t_page;
    t_stack;
    t_ports;
    t_misc;
    t_reset(2, 1'b0, 8'h0d, 8'h82);
    stop_test;
  end
endmodule : core_sfr_pc_stack_ports_tb
